// file: logic/ies_cfg.svh
`ifndef IES_CFG_SVH
`define IES_CFG_SVH

// Register byte offsets
`define IES_OFF_INSTR 12'h000
`define IES_OFF_WORK 12'h004
`define IES_OFF_STATUS 12'h008
`define IES_OFF_TMODE 12'h00C
`define IES_OFF_WATCH 12'h010
// Register windows: special bank and data file
`define IES_SPECIAL_BASE 4'h1
`define IES_DATA_BASE 3'h1
`define IES_SPECIAL_COUNT 6'h16
`define IES_DATA_COUNT 128

// Instruction word fields
`define IES_OP_LSB 0
`define IES_OP_MSB 3
`define IES_DEST_BIT 4
`define IES_ADDR_LSB 8
`define IES_ADDR_MSB 14
`define IES_IMM_LSB 16
`define IES_IMM_MSB 23

// Status word fields
`define IES_ST_CARRY 0
`define IES_ST_HALF 1
`define IES_ST_ZERO 2
`define IES_ST_PD_N 3
`define IES_ST_TO_N 4
`define IES_ST_HALT 5

// Watchdog word fields
`define IES_WD_CNT_LSB 0
`define IES_WD_PRE_LSB 8

// Reset values
`define IES_RST_BYTE 8'h00
`define IES_RST_TO_N 1'b1
`define IES_RST_PD_N 1'b1

// Opcodes
`define IES_OPC_LOAD_BANK 4'h1
`define IES_OPC_READ_BANK 4'h2
`define IES_OPC_REG_SUB 4'h3
`define IES_OPC_IMM_SUB 4'h4
`define IES_OPC_NIBBLE 4'h5
`define IES_OPC_TMODE 4'h6
`define IES_OPC_HALT 4'h7

`endif

// file: logic/ies_pkg.sv
package ies_pkg;

    // Execution state, one-hot
    typedef enum logic [1:0] {
        IES_RUN = 2'b01,
        IES_HALT = 2'b10
    } ies_state_e;

    // Decoded instruction word
    typedef struct packed {
        logic [3:0] opcode;
        logic dest;
        logic [6:0] reg_addr;
        logic [7:0] imm;
    } ies_instr_s;

    // Subtract result with flags
    typedef struct packed {
        logic [7:0] diff;
        logic carry;
        logic half_carry;
        logic zero;
    } ies_sub_s;

    // Whole state of the executor
    typedef struct packed {
        logic [127:0][7:0] data_regs;
        logic [21:0][7:0] special_register;
        logic [7:0] working_register;
        logic [7:0] timer_zero_mode_reg;
        logic [7:0] watchdog_counter;
        logic [7:0] watchdog_prescaler;
        logic carry_flag;
        logic half_carry_flag;
        logic zero_flag;
        logic timeout_flag_n;
        logic powerdown_flag_n;
        ies_state_e state;
        logic [11:0] ap_addr;
        logic ap_hi_ok;
        logic dp_write;
        logic rd_pend;
        logic [31:0] hrdata;
        logic hreadyout;
    } ies_regs_s;

endpackage

// file: logic/ies_sub_unit.sv
`timescale 1ns/1ps
// Minuend minus subtrahend, carry as inverted borrow
module ies_sub_unit
    import ies_pkg::*;
(
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    output ies_sub_s result
);
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // Two's complement add of the inverted subtrahend
    assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;

    // Result and flags
    assign result.diff = full_sum[7:0];
    assign result.carry = full_sum[8]; // [RULE12]
    assign result.half_carry = low_sum[4];
    assign result.zero = (full_sum[7:0] == 8'h00); // [RULE13]
endmodule

// file: logic/ies_exec.sv
`timescale 1ns/1ps
`include "ies_cfg.svh"
// What this block does
// [RULE1] Bank load copies working register into special register 0..21, flags kept.
// [RULE2] Bank read copies special register 0..21 into working register, source kept.
// [RULE3] Register subtract: data register minus working register, sets zero, half, carry.
// [RULE4] Register subtract result to working register if dest 0, else to register.
// [RULE5] Immediate subtract: immediate minus working register into working register, flags.
// [RULE6] Halt entry clears watchdog counter and its prescaler.
// [RULE7] Halt entry sets timeout flag, clears powerdown flag, others kept.
// [RULE8] After halt entry execution stops in the halt state.
// [RULE9] Nibble exchange swaps high and low nibbles of the addressed register.
// [RULE10] Nibble exchange result to working register or register by dest; flags kept.
// [RULE11] Timer mode load copies working register into timer zero mode register.
// [RULE12] Subtract carry is an inverted borrow.
// [RULE13] Zero flag set exactly when the subtract result is zero.
module ies_exec
    import ies_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic halted,
    output logic [7:0] timer_zero_mode
);
    ies_regs_s cur;
    ies_regs_s nxt;
    ies_instr_s instr;
    ies_sub_s sub_res;
    logic [7:0] sub_minuend;
    logic [7:0] src_byte;
    logic [7:0] swap_byte;
    logic bus_take;
    logic exec_go;
    logic spec_ok;
    logic [4:0] spec_idx;
    logic wr_spec;
    logic wr_data;
    logic rd_spec;
    logic rd_data;
    logic resp_r;
    logic [31:0] status_word;
    logic [31:0] watch_word;
    logic [31:0] read_word;

    // Instruction fields straight from the write data
    always_comb
    begin
        instr.opcode = hwdata[`IES_OP_MSB:`IES_OP_LSB];
        instr.dest = hwdata[`IES_DEST_BIT];
        instr.reg_addr = hwdata[`IES_ADDR_MSB:`IES_ADDR_LSB];
        instr.imm = hwdata[`IES_IMM_MSB:`IES_IMM_LSB];
    end

    // Operands for the subtractor and the swap
    always_comb
    begin
        spec_idx = instr.reg_addr[4:0];
        spec_ok = ({1'b0, instr.reg_addr[5:0]} < {1'b0, `IES_SPECIAL_COUNT})
            && !instr.reg_addr[6];
        src_byte = cur.data_regs[instr.reg_addr];
        swap_byte = {src_byte[3:0], src_byte[7:4]}; // [RULE9]
        if (instr.opcode == `IES_OPC_IMM_SUB)
        begin
            sub_minuend = instr.imm; // [RULE5]
        end
        else
        begin
            sub_minuend = src_byte; // [RULE3]
        end
    end

    ies_sub_unit u_sub (
        .minuend(sub_minuend),
        .subtrahend(cur.working_register),
        .result(sub_res)
    );

    // Bus address phase and register window decode
    always_comb
    begin
        bus_take = hsel && htrans[1] && hready;
        exec_go = cur.dp_write && cur.ap_hi_ok && (cur.ap_addr == `IES_OFF_INSTR);
        wr_spec = cur.dp_write && cur.ap_hi_ok && (cur.ap_addr[11:8] == `IES_SPECIAL_BASE)
            && ({1'b0, cur.ap_addr[7:2]} < {1'b0, `IES_SPECIAL_COUNT});
        wr_data = cur.dp_write && cur.ap_hi_ok && (cur.ap_addr[11:9] == `IES_DATA_BASE);
        rd_spec = cur.ap_hi_ok && (cur.ap_addr[11:8] == `IES_SPECIAL_BASE)
            && ({1'b0, cur.ap_addr[7:2]} < {1'b0, `IES_SPECIAL_COUNT});
        rd_data = cur.ap_hi_ok && (cur.ap_addr[11:9] == `IES_DATA_BASE);
    end

    // Status and watchdog words as software sees them
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[`IES_ST_CARRY] = cur.carry_flag;
        status_word[`IES_ST_HALF] = cur.half_carry_flag;
        status_word[`IES_ST_ZERO] = cur.zero_flag;
        status_word[`IES_ST_PD_N] = cur.powerdown_flag_n;
        status_word[`IES_ST_TO_N] = cur.timeout_flag_n;
        status_word[`IES_ST_HALT] = (cur.state == IES_HALT);
        watch_word = 32'h0000_0000;
        watch_word[`IES_WD_CNT_LSB +: 8] = cur.watchdog_counter;
        watch_word[`IES_WD_PRE_LSB +: 8] = cur.watchdog_prescaler;
    end

    // Read mux: byte registers in bits 7:0, unmapped words read zero
    always_comb
    begin
        read_word = 32'h0000_0000;
        if (rd_spec)
        begin
            read_word[7:0] = cur.special_register[cur.ap_addr[6:2]];
        end
        else if (rd_data)
        begin
            read_word[7:0] = cur.data_regs[cur.ap_addr[8:2]];
        end
        else if (cur.ap_hi_ok)
        begin
            // Fixed-address registers
            case (cur.ap_addr)
                `IES_OFF_WORK:
                begin
                    read_word[7:0] = cur.working_register;
                end
                `IES_OFF_STATUS:
                begin
                    read_word = status_word;
                end
                `IES_OFF_TMODE:
                begin
                    read_word[7:0] = cur.timer_zero_mode_reg;
                end
                `IES_OFF_WATCH:
                begin
                    read_word = watch_word;
                end
                default:
                begin
                    read_word = 32'h0000_0000;
                end
            endcase
        end
    end

    // Next state: bus slave, register writes, instruction execution
    always_comb
    begin
        nxt = cur;
        // Data phase of a write ends here; clear pending write
        if (hready)
        begin
            nxt.dp_write = 1'b0;
        end
        // Read data phase: one wait cycle, then data from the current state
        if (cur.rd_pend)
        begin
            nxt.rd_pend = 1'b0;
            nxt.hreadyout = 1'b1;
            nxt.hrdata = read_word;
        end
        // Plain register writes
        if (wr_spec)
        begin
            nxt.special_register[cur.ap_addr[6:2]] = hwdata[7:0];
        end
        if (wr_data)
        begin
            nxt.data_regs[cur.ap_addr[8:2]] = hwdata[7:0];
        end
        // Fixed-address register writes
        if (cur.dp_write && cur.ap_hi_ok)
        begin
            case (cur.ap_addr)
                `IES_OFF_WORK:
                begin
                    nxt.working_register = hwdata[7:0];
                end
                `IES_OFF_STATUS:
                begin
                    nxt.carry_flag = hwdata[`IES_ST_CARRY];
                    nxt.half_carry_flag = hwdata[`IES_ST_HALF];
                    nxt.zero_flag = hwdata[`IES_ST_ZERO];
                    nxt.powerdown_flag_n = hwdata[`IES_ST_PD_N];
                    nxt.timeout_flag_n = hwdata[`IES_ST_TO_N];
                    // Writing halt bit low wakes the executor
                    if (!hwdata[`IES_ST_HALT])
                    begin
                        nxt.state = IES_RUN;
                    end
                end
                `IES_OFF_TMODE:
                begin
                    nxt.timer_zero_mode_reg = hwdata[7:0];
                end
                `IES_OFF_WATCH:
                begin
                    nxt.watchdog_counter = hwdata[`IES_WD_CNT_LSB +: 8];
                    nxt.watchdog_prescaler = hwdata[`IES_WD_PRE_LSB +: 8];
                end
                default:
                begin
                    nxt.state = cur.state;
                end
            endcase
        end
        // Instruction execution, one cycle each, ignored while halted
        if (exec_go)
        begin
            case (cur.state)
                // Running: decode the opcode
                IES_RUN:
                begin
                    case (instr.opcode)
                        // Working register out to the special bank
                        `IES_OPC_LOAD_BANK:
                        begin
                            if (spec_ok)
                            begin
                                nxt.special_register[spec_idx] = cur.working_register; // [RULE1]
                            end
                        end
                        // Special bank back into the working register
                        `IES_OPC_READ_BANK:
                        begin
                            if (spec_ok)
                            begin
                                nxt.working_register = cur.special_register[spec_idx]; // [RULE2]
                            end
                        end
                        // Data register minus working register
                        `IES_OPC_REG_SUB:
                        begin
                            // [RULE3]
                            nxt.carry_flag = sub_res.carry;
                            nxt.half_carry_flag = sub_res.half_carry;
                            nxt.zero_flag = sub_res.zero;
                            if (instr.dest)
                            begin
                                nxt.data_regs[instr.reg_addr] = sub_res.diff; // [RULE4]
                            end
                            else
                            begin
                                nxt.working_register = sub_res.diff; // [RULE4]
                            end
                        end
                        // Immediate minus working register, always to working
                        `IES_OPC_IMM_SUB:
                        begin
                            // [RULE5]
                            nxt.working_register = sub_res.diff;
                            nxt.carry_flag = sub_res.carry;
                            nxt.half_carry_flag = sub_res.half_carry;
                            nxt.zero_flag = sub_res.zero;
                        end
                        // Nibble exchange, destination by dest bit
                        `IES_OPC_NIBBLE:
                        begin
                            if (instr.dest)
                            begin
                                nxt.data_regs[instr.reg_addr] = swap_byte; // [RULE10]
                            end
                            else
                            begin
                                nxt.working_register = swap_byte; // [RULE10]
                            end
                        end
                        // Working register into timer zero mode
                        `IES_OPC_TMODE:
                        begin
                            nxt.timer_zero_mode_reg = cur.working_register; // [RULE11]
                        end
                        // Halt entry: watchdog cleared, timeout flag set, powerdown flag cleared, then stop
                        `IES_OPC_HALT:
                        begin
                            nxt.watchdog_counter = `IES_RST_BYTE; // [RULE6]
                            nxt.watchdog_prescaler = `IES_RST_BYTE; // [RULE6]
                            nxt.timeout_flag_n = 1'b1; // [RULE7]
                            nxt.powerdown_flag_n = 1'b0; // [RULE7]
                            nxt.state = IES_HALT; // [RULE8]
                        end
                        // Unused opcodes leave all state alone
                        default:
                        begin
                            nxt.state = IES_RUN;
                        end
                    endcase
                end
                // Halted: instruction writes are dropped
                IES_HALT:
                begin
                    nxt.state = IES_HALT; // [RULE8]
                end
                default:
                begin
                    nxt.state = IES_RUN;
                end
            endcase
        end
        // New address phase
        if (bus_take)
        begin
            nxt.ap_addr = haddr[11:0];
            nxt.ap_hi_ok = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'b00);
            nxt.dp_write = hwrite;
            nxt.rd_pend = !hwrite;
            nxt.hreadyout = hwrite;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cur <= '0;
            cur.timeout_flag_n <= `IES_RST_TO_N;
            cur.powerdown_flag_n <= `IES_RST_PD_N;
            cur.state <= IES_RUN;
            cur.hreadyout <= 1'b1;
            resp_r <= 1'b0;
        end
        else
        begin
            cur <= nxt;
            resp_r <= 1'b0;
        end
    end

    // Outputs straight from flops
    assign hreadyout = cur.hreadyout;
    assign hrdata = cur.hrdata;
    assign hresp = resp_r;
    assign halted = cur.state[1]; // One-hot halt bit
    assign timer_zero_mode = cur.timer_zero_mode_reg;
endmodule

// file: verification/ies_exec_chk.sv
`timescale 1ns/1ps
`include "ies_cfg.svh"
// Port-level watch on bus timing, halt entry and timer mode updates
module ies_exec_chk
    import ies_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic halted,
    input wire logic [7:0] timer_zero_mode
);
    logic wr_dp_r;
    logic [11:0] wr_addr_r;
    logic taken;
    logic halt_wr;
    logic tm_wr;
    logic st_wr;
    // Decode of the write data phase in flight
    assign taken = hsel && htrans[1] && hready;
    assign halt_wr = wr_dp_r && wr_addr_r == `IES_OFF_INSTR && hwdata[3:0] == `IES_OPC_HALT;
    assign st_wr = wr_dp_r && wr_addr_r == `IES_OFF_STATUS;
    assign tm_wr = wr_dp_r && (wr_addr_r == `IES_OFF_TMODE
        || (wr_addr_r == `IES_OFF_INSTR && hwdata[3:0] == `IES_OPC_TMODE));
    // Remember write address phases
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_dp_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end
        else if (hready)
        begin
            wr_dp_r <= taken && hwrite;
            wr_addr_r <= haddr[11:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_halt_entry: assert property (halt_wr && !halted |=> halted)
        else $error("halt not entered");
    a_halt_cause: assert property ($rose(halted) |-> $past(halt_wr))
        else $error("halt without halt instruction");
    a_halt_holds: assert property (halted && !st_wr |=> halted)
        else $error("halt left early");
    a_run_holds: assert property (!halted && !halt_wr && !st_wr |=> !halted)
        else $error("halt entered early");
    a_tmode_cause: assert property ($changed(timer_zero_mode) |-> $past(tm_wr))
        else $error("timer mode changed unasked");
endmodule
bind ies_exec ies_exec_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .halted(halted), .timer_zero_mode(timer_zero_mode));

// file: verification/mcu_instr_exec_subset_bench.sv
`timescale 1ns/1ps
`include "ies_cfg.svh"
module mcu_instr_exec_subset_bench
    import ies_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, halted, rdy_n;
    logic [31:0] hrdata, rd_n, seed;
    logic [7:0] timer_zero_mode, m, s, res;
    logic [7:0] cm [6] = '{8'h06, 8'h05, 8'h37, 8'h10, 8'hFF, 8'h00};
    logic [7:0] cs [6] = '{8'h05, 8'h06, 8'h37, 8'h01, 8'h00, 8'hFF};
    logic [10:0] q;
    logic [6:0] r;
    logic [5:0] st;
    logic [3:0] op;
    logic tr;
    int bad_count = 0;
    int total_checks = 0;
    int j;
    always #5 hclk = ~hclk;
    // Bus answer as seen at the next rising edge
    always @(negedge hclk)
    begin
        rdy_n <= hreadyout;
        rd_n <= hrdata;
    end
    ies_exec u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .halted(halted),
        .timer_zero_mode(timer_zero_mode));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Difference with zero, half carry and carry as no-borrow
    function automatic logic [10:0] sub(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {d == 8'h00, a[3:0] >= b[3:0], a >= b, d};
    endfunction
    function automatic logic [31:0] ins(input logic [3:0] o, input logic dd,
        input logic [6:0] ra, input logic [7:0] im);
        return {8'h00, im, 1'b0, ra, 3'h0, dd, o};
    endfunction
    function automatic logic [11:0] ad(input logic [11:0] b, input int i);
        return b + 12'(4 * i);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        total_checks++;
        if (got !== ex)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, ex);
        end
    endtask
    // One single AHB-Lite transfer
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (rdy_n !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (rdy_n !== 1'b1);
        rd = rd_n;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] x;
        xfer(a, 1'b1, wd, x);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] ex);
        logic [31:0] x;
        xfer(a, 1'b0, 32'h0, x);
        chk(x, ex);
    endtask
    task automatic summarize();
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog against a hung bus
    initial
    begin
        #300000;
        bad_count++;
        summarize();
    end
    initial
    begin
        seed = 32'h0000_0057;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        st = 6'h18;
        // Reset values and an unmapped hole
        rc(`IES_OFF_STATUS, 32'h18);
        rc(`IES_OFF_TMODE, 32'h0);
        rc(12'h040, 32'h0);
        // Bank load and read, both ends of the index range
        for (int k = 0; k < 6; k++)
        begin
            j = (k < 2) ? 21 * k : int'(rnd() % 22);
            s = 8'(rnd());
            m = 8'(rnd());
            wr(`IES_OFF_WORK, 32'(s));
            wr(`IES_OFF_INSTR, ins(`IES_OPC_LOAD_BANK, 1'b0, 7'(j), 8'h00));
            rc(ad(12'h100, j), 32'(s));
            wr(ad(12'h100, j), 32'(m));
            wr(`IES_OFF_INSTR, ins(`IES_OPC_READ_BANK, 1'b0, 7'(j), 8'h00));
            rc(`IES_OFF_WORK, 32'(m));
            rc(ad(12'h100, j), 32'(m));
        end
        // Index past the bank and an unused opcode change nothing
        wr(`IES_OFF_INSTR, ins(`IES_OPC_READ_BANK, 1'b0, 7'h16, 8'h00));
        rc(`IES_OFF_WORK, 32'(m));
        wr(`IES_OFF_INSTR, ins(4'hF, 1'b1, 7'h00, 8'h00));
        rc(`IES_OFF_STATUS, 32'(st));
        // Both subtracts and nibble exchange, corners first
        for (int k = 0; k < 30; k++)
        begin
            m = (k < 6) ? cm[k] : 8'(rnd());
            s = (k < 6) ? cs[k] : 8'(rnd());
            r = (k == 0) ? 7'h7F : 7'(rnd());
            op = (k % 3 == 0) ? `IES_OPC_REG_SUB : (k % 3 == 1) ? `IES_OPC_IMM_SUB
                : `IES_OPC_NIBBLE;
            q = sub(m, s);
            res = (op == `IES_OPC_NIBBLE) ? {m[3:0], m[7:4]} : q[7:0];
            tr = k[2] && op != `IES_OPC_IMM_SUB;
            wr(ad(12'h200, int'(r)), 32'(m));
            wr(`IES_OFF_WORK, 32'(s));
            wr(`IES_OFF_INSTR, ins(op, k[2], r, m));
            if (op != `IES_OPC_NIBBLE)
                st[2:0] = q[10:8];
            rc(`IES_OFF_STATUS, 32'(st));
            rc(`IES_OFF_WORK, 32'(tr ? s : res));
            rc(ad(12'h200, int'(r)), 32'(tr ? res : m));
        end
        // Timer mode load
        s = 8'(rnd());
        wr(`IES_OFF_WORK, 32'(s));
        wr(`IES_OFF_INSTR, ins(`IES_OPC_TMODE, 1'b0, 7'h00, 8'h00));
        rc(`IES_OFF_TMODE, 32'(s));
        chk({24'h0, timer_zero_mode}, 32'(s));
        rc(`IES_OFF_STATUS, 32'(st));
        // Halt entry from timeout low, then an ignored instruction
        wr(`IES_OFF_WATCH, rnd() & 32'hFFFF);
        wr(`IES_OFF_STATUS, 32'h0D);
        wr(`IES_OFF_INSTR, ins(`IES_OPC_HALT, 1'b0, 7'h00, 8'h00));
        rc(`IES_OFF_WATCH, 32'h0);
        rc(`IES_OFF_STATUS, 32'h35);
        chk({31'h0, halted}, 32'h1);
        wr(`IES_OFF_WORK, 32'(~s));
        wr(`IES_OFF_INSTR, ins(`IES_OPC_TMODE, 1'b0, 7'h00, 8'h00));
        rc(`IES_OFF_TMODE, 32'(s));
        wr(`IES_OFF_STATUS, 32'h18);
        // Wake lands at the edge that ends the write; look once it has settled
        @(negedge hclk);
        chk({31'h0, halted}, 32'h0);
        summarize();
    end
endmodule
